// ### logic/csc_pkg.sv
// clock source control: shared constants, register map and types
// assumes a single 10 MHz control clock and word-aligned register offsets
package csc_pkg;
  // control clock period
  localparam int CLK_NS = 100;
  // source codes, also the bit index in the gate enable vector
  localparam int NUM_SRC = 5;
  localparam logic [2:0] SRC_MAIN = 3'h0;
  localparam logic [2:0] SRC_LOWSPD = 3'h1;
  localparam logic [2:0] SRC_XTAL = 3'h2;
  localparam logic [2:0] SRC_WATCH = 3'h3;
  localparam logic [2:0] SRC_PIN = 3'h4;
  localparam logic [2:0] SRC_RST = SRC_MAIN;
  // register offsets
  localparam logic [7:0] OFS_SRC_SEL = 8'h00;
  localparam logic [7:0] OFS_MAIN_FREQ = 8'h04;
  localparam logic [7:0] OFS_TRIM_IDX = 8'h08;
  localparam logic [7:0] OFS_TRIM_DATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CAL_CTRL = 8'h14;
  localparam logic [7:0] OFS_CAL_COUNT = 8'h18;
  // status and calibration control field positions
  localparam int ST_ACT_LSB = 0;
  localparam int ST_BUSY = 3;
  localparam int ST_ERR = 4;
  localparam int ST_RDY_LSB = 5;
  localparam int CAL_BUSY_BIT = 16;
  // main oscillator and crystal frequencies in MHz
  localparam logic [5:0] FREQ_RST = 6'h18;
  localparam logic [5:0] FREQ_MIN = 6'h03;
  localparam logic [5:0] FREQ_MAX = 6'h30;
  localparam logic [5:0] XTAL_MHZ = 6'h18;
  // flash wait thresholds: above WS1 one state, above WS2 two states
  localparam logic [5:0] FREQ_WS1 = 6'h0c;
  localparam logic [5:0] FREQ_WS2 = 6'h18;
  localparam logic [1:0] WS_MAX = 2'h2;
  // dead time with every gate closed between two sources
  localparam int GAP_NS = 400;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  // longest wait for a new source to report running
  localparam int RDY_TIMEOUT_US = 1000;
  localparam int RDY_TIMEOUT_CYC = RDY_TIMEOUT_US * 1000 / CLK_NS;
  // switch sequencer states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT_RDY, SEQ_GAP} csc_seq_t;
endpackage

// ### logic/csc_sync.sv
// two-flop synchroniser bank for asynchronous levels
// assumes inputs are levels that hold for several clock periods
`timescale 1ns/1ps
`default_nettype none
module csc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // async levels in, synchronised levels out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r; // first stage, read only by the second
      logic hold_r; // second stage
      // plain two-stage capture per bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          meta_r <= din[i];
          hold_r <= meta_r;
        end
      end
      assign dout[i] = hold_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ### logic/csc_trim_mem.sv
// per-frequency trim table loaded by software from flash
// assumes one write port and one registered read port on the same clock
`timescale 1ns/1ps
`default_nettype none
module csc_trim_mem (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // write port
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port, data one cycle after address
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:63]; // table storage, no reset
  logic [63:0] valid_r; // entries written since reset
  // storage write
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  // valid flags keep unwritten entries from reading as unknown
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      valid_r <= 64'h0;
    end else if (wr_en) begin
      valid_r[wr_addr] <= 1'b1;
    end
  end
  // registered read, zero trim for an empty entry
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= valid_r[rd_addr] ? mem[rd_addr] : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### logic/csc_clk_ctrl.sv
// clock source control: source selection with break-before-make gating,
// main oscillator frequency and trim, radio clock enables, flash wait
// states and low-speed calibration counter
// assumes gate enables drive glitch-free clock gate cells per source
//
// Contract
// RULE_01 - source changes never glitch the output clock
// RULE_02 - no flip-flop goes metastable on switching
// RULE_03 - five selectable sources incl. pin clock
// RULE_04 - main oscillator resets 24 MHz, 3..48 step 1
// RULE_05 - trim from latches plus flash-loaded adjustments
// RULE_06 - crystal clock feeds radio active clock
// RULE_07 - crystal clock also selectable as system clock
// RULE_08 - watch crystal feeds radio sleep clock
// RULE_09 - low-speed oscillator clocks peripherals in deep sleep
// RULE_10 - low-speed counters measurable against main oscillator
// RULE_11 - flash: two waits at 48, one at 24
// RULE_12 - commit switch only once new source runs
`timescale 1ns/1ps
`default_nettype none
module csc_clk_ctrl import csc_pkg::*; #(
  parameter int RDY_TIMEOUT = RDY_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // oscillator status and pins, asynchronous
  input wire logic [4:0] OSC_RDY,
  input wire logic LOW_SPEED_CLK_IN,
  input wire logic [7:0] TRIM_LATCH_IN,
  // clock gate enables and oscillator settings
  output logic [4:0] SRC_EN,
  output logic [2:0] ACTIVE_SRC,
  output logic [5:0] MAIN_FREQ_MHZ,
  output logic [7:0] MAIN_TRIM,
  // consumers
  output logic RADIO_ACT_CLK_EN,
  output logic RADIO_SLP_CLK_EN,
  output logic LP_PERIPH_CLK_EN,
  output logic [1:0] FLASH_WAIT
);
  // one-hot gate pattern for a source code
  function automatic logic [4:0] onehot(input logic [2:0] s);
    onehot = 5'h01 << s;
  endfunction

  // flash wait states for a source at a main oscillator setting
  function automatic logic [1:0] ws_of(input logic [2:0] s, input logic [5:0] f);
    logic [5:0] mhz;
    mhz = (s == SRC_MAIN) ? f : ((s == SRC_XTAL) ? XTAL_MHZ : 6'h00);
    if (s == SRC_PIN) begin
      ws_of = WS_MAX; // pin rate unknown, stay safe
    end else if (mhz > FREQ_WS2) begin
      ws_of = 2'h2;
    end else if (mhz > FREQ_WS1) begin
      ws_of = 2'h1;
    end else begin
      ws_of = 2'h0;
    end
  endfunction

  // synchronised inputs
  logic [13:0] sync_out;
  logic [4:0] rdy_s; // running flags per source
  logic lsclk_s; // low-speed clock level
  logic [7:0] latch_s; // factory trim lines
  // every async input crosses two flops first
  csc_sync #(.W(14)) u_sync ( // RULE_02
    .clk(CLK),
    .resetn(RESETN),
    .din({TRIM_LATCH_IN, LOW_SPEED_CLK_IN, OSC_RDY}),
    .dout(sync_out)
  );
  assign rdy_s = sync_out[4:0];
  assign lsclk_s = sync_out[5];
  assign latch_s = sync_out[13:6];

  // software registers
  logic [2:0] req_src_r; // requested source
  logic [5:0] freq_r; // main oscillator setting
  logic [5:0] trim_idx_r; // table write index
  logic err_r; // sticky timeout flag
  logic [15:0] cal_win_r; // calibration window in low-speed periods
  logic [31:0] cal_cnt_r; // main clock cycles counted
  logic cal_busy_r;
  logic cal_arm_r; // waiting for first low-speed edge
  logic [15:0] cal_edges_r;
  logic ls_prev_r; // edge detect on synchronised level
  // sequencer
  csc_seq_t state_r;
  logic [2:0] tgt_r; // source being switched to
  logic [2:0] act_src_r; // committed source
  logic [13:0] cnt_r; // wait and gap counter
  logic abort_r; // timeout pulse
  // strap capture
  logic [7:0] latch_r;
  logic [1:0] caught_r; // edges since release, trim taken until three
  logic [7:0] tbl_data;
  logic wr_sel, wr_freq, wr_tdata, wr_stat, wr_cal;
  logic ls_rise;

  assign wr_sel = WR && (ADDR == OFS_SRC_SEL);
  assign wr_freq = WR && (ADDR == OFS_MAIN_FREQ);
  assign wr_tdata = WR && (ADDR == OFS_TRIM_DATA);
  assign wr_stat = WR && (ADDR == OFS_STATUS);
  assign wr_cal = WR && (ADDR == OFS_CAL_CTRL);
  assign ls_rise = lsclk_s && !ls_prev_r;

  // source request; an unknown code is ignored, a timeout reverts it
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      req_src_r <= SRC_RST;
    end else if (abort_r) begin
      req_src_r <= act_src_r;
    end else if (wr_sel && WDATA[2:0] < 3'(NUM_SRC)) begin // RULE_03 RULE_07
      req_src_r <= WDATA[2:0];
    end
  end

  // frequency setting clamped to the legal range
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      freq_r <= FREQ_RST; // RULE_04
    end else if (wr_freq) begin
      if (WDATA[31:6] != 26'h0 || WDATA[5:0] > FREQ_MAX) begin
        freq_r <= FREQ_MAX;
      end else if (WDATA[5:0] < FREQ_MIN) begin
        freq_r <= FREQ_MIN;
      end else begin
        freq_r <= WDATA[5:0]; // RULE_04
      end
    end
  end

  // trim table index
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      trim_idx_r <= 6'h00;
    end else if (WR && ADDR == OFS_TRIM_IDX) begin
      trim_idx_r <= WDATA[5:0];
    end
  end

  // timeout flag: a new timeout wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      err_r <= 1'b0;
    end else if (abort_r) begin
      err_r <= 1'b1;
    end else if (wr_stat && WDATA[ST_ERR]) begin
      err_r <= 1'b0;
    end
  end

  // factory trim taken until the synchroniser has filled; its first two
  // edges after release still show reset zeros, lines are static
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      latch_r <= 8'h00;
      caught_r <= 2'h0;
    end else if (caught_r != 2'h3) begin
      latch_r <= latch_s; // RULE_05
      caught_r <= caught_r + 2'h1;
    end
  end

  // flash-loaded adjustment per frequency setting
  csc_trim_mem u_trim (
    .clk(CLK),
    .resetn(RESETN),
    .wr_en(wr_tdata),
    .wr_addr(trim_idx_r),
    .wr_data(WDATA[7:0]),
    .rd_addr(freq_r),
    .rd_data(tbl_data)
  );

  // switch sequencer: wait running, close all gates, then open new one
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= SEQ_IDLE;
      tgt_r <= SRC_RST;
      act_src_r <= SRC_RST;
      cnt_r <= 14'h0;
      abort_r <= 1'b0;
      SRC_EN <= onehot(SRC_RST);
    end else begin
      abort_r <= 1'b0;
      case (state_r)
        SEQ_IDLE: begin
          cnt_r <= 14'h0;
          // a refused request is still reverting in the abort cycle
          if (!abort_r && req_src_r != act_src_r) begin
            tgt_r <= req_src_r;
            state_r <= SEQ_WAIT_RDY;
          end
        end
        SEQ_WAIT_RDY: begin
          // old gate stays open until the new source reports running
          if (rdy_s[tgt_r]) begin // RULE_12
            SRC_EN <= 5'h00; // RULE_01
            cnt_r <= 14'h0;
            state_r <= SEQ_GAP;
          end else if (int'(cnt_r) >= RDY_TIMEOUT - 1) begin
            abort_r <= 1'b1; // give up, stay on old source
            state_r <= SEQ_IDLE;
          end else begin
            cnt_r <= cnt_r + 14'h1;
          end
        end
        SEQ_GAP: begin
          // dead time lets both gate cells settle on a low clock
          if (int'(cnt_r) >= GAP_CYC - 1) begin
            SRC_EN <= onehot(tgt_r); // RULE_01 RULE_02
            act_src_r <= tgt_r; // RULE_12
            state_r <= SEQ_IDLE;
          end else begin
            cnt_r <= cnt_r + 14'h1;
          end
        end
        default: begin
          state_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // oscillator settings and status outputs
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ACTIVE_SRC <= SRC_RST;
      MAIN_FREQ_MHZ <= FREQ_RST;
      MAIN_TRIM <= 8'h00;
    end else begin
      ACTIVE_SRC <= act_src_r;
      MAIN_FREQ_MHZ <= freq_r;
      MAIN_TRIM <= latch_r + tbl_data; // RULE_05
    end
  end

  // wait states track the clock; held at maximum while switching
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      FLASH_WAIT <= WS_MAX;
    end else if (state_r != SEQ_IDLE) begin
      FLASH_WAIT <= WS_MAX;
    end else begin
      FLASH_WAIT <= ws_of(act_src_r, freq_r); // RULE_11
    end
  end

  // consumer clock enables follow their oscillators directly
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RADIO_ACT_CLK_EN <= 1'b0;
      RADIO_SLP_CLK_EN <= 1'b0;
      LP_PERIPH_CLK_EN <= 1'b0;
    end else begin
      RADIO_ACT_CLK_EN <= rdy_s[SRC_XTAL]; // RULE_06
      RADIO_SLP_CLK_EN <= rdy_s[SRC_WATCH]; // RULE_08
      // not tied to any power mode, so it runs on through deep sleep
      LP_PERIPH_CLK_EN <= rdy_s[SRC_LOWSPD]; // RULE_09
    end
  end

  // calibration: main clock cycles across a window of low-speed periods
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ls_prev_r <= 1'b0;
      cal_win_r <= 16'h0;
      cal_cnt_r <= 32'h0;
      cal_busy_r <= 1'b0;
      cal_arm_r <= 1'b0;
      cal_edges_r <= 16'h0;
    end else begin
      ls_prev_r <= lsclk_s;
      if (wr_cal) begin
        cal_win_r <= WDATA[15:0];
        cal_busy_r <= (WDATA[15:0] != 16'h0);
        cal_arm_r <= (WDATA[15:0] != 16'h0);
        cal_cnt_r <= 32'h0;
        cal_edges_r <= 16'h0;
      end else if (cal_arm_r) begin
        cal_arm_r <= !ls_rise; // start on a period boundary
      end else if (cal_busy_r) begin
        cal_cnt_r <= cal_cnt_r + 32'h1; // RULE_10
        if (ls_rise) begin
          cal_edges_r <= cal_edges_r + 16'h1;
          cal_busy_r <= (cal_edges_r + 16'h1 != cal_win_r);
        end
      end
    end
  end

  // register read, data valid only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      case (ADDR)
        OFS_SRC_SEL: RDATA <= {29'h0, req_src_r};
        OFS_MAIN_FREQ: RDATA <= {26'h0, freq_r};
        OFS_TRIM_IDX: RDATA <= {26'h0, trim_idx_r};
        OFS_TRIM_DATA: RDATA <= {24'h0, latch_r};
        OFS_STATUS: RDATA <= {22'h0, rdy_s, err_r, (state_r != SEQ_IDLE), act_src_r};
        OFS_CAL_CTRL: RDATA <= {15'h0, cal_busy_r, cal_win_r};
        OFS_CAL_COUNT: RDATA <= cal_cnt_r;
        default: RDATA <= 32'h0;
      endcase
    end else begin
      RDATA <= 32'h0;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  src_onehot_a: assert property ($onehot0(SRC_EN)) // RULE_01
    else $error("more than one clock gate open");
  gate_gap_a: assert property ((|SRC_EN && $past(SRC_EN) != SRC_EN) |-> // RULE_01
      ($past(SRC_EN, 1) == 5'h0 && $past(SRC_EN, 2) == 5'h0 &&
       $past(SRC_EN, 3) == 5'h0 && $past(SRC_EN, 4) == 5'h0))
    else $error("new gate opened without full dead time");
  hold_old_a: assert property (state_r == SEQ_WAIT_RDY |-> SRC_EN == onehot(act_src_r)) // RULE_12
    else $error("old source dropped before new one runs");
  confirm_rdy_a: assert property (($past(state_r) == SEQ_WAIT_RDY && state_r == SEQ_GAP) // RULE_12
      |-> $past(rdy_s[tgt_r]))
    else $error("switch committed to a stopped source");
  freq_range_a: assert property (MAIN_FREQ_MHZ >= FREQ_MIN && MAIN_FREQ_MHZ <= FREQ_MAX) // RULE_04
    else $error("main oscillator setting out of range");
  ws_fast_a: assert property (($past(RESETN) && $past(state_r) == SEQ_IDLE && // RULE_11
      ACTIVE_SRC == SRC_MAIN && MAIN_FREQ_MHZ == 6'h30) |-> FLASH_WAIT == 2'h2)
    else $error("flash wait not two at 48 MHz");
  ws_mid_a: assert property (($past(RESETN) && $past(state_r) == SEQ_IDLE && // RULE_11
      ACTIVE_SRC == SRC_MAIN && MAIN_FREQ_MHZ == 6'h18) |-> FLASH_WAIT == 2'h1)
    else $error("flash wait not one at 24 MHz");
  radio_act_a: assert property (rdy_s[SRC_XTAL] ##1 rdy_s[SRC_XTAL] |-> RADIO_ACT_CLK_EN) // RULE_06
    else $error("radio active clock missing while crystal runs");
  radio_slp_a: assert property ($fell(rdy_s[SRC_WATCH]) |=> !RADIO_SLP_CLK_EN) // RULE_08
    else $error("radio sleep clock kept after watch crystal stop");
  lp_keep_a: assert property ($rose(rdy_s[SRC_LOWSPD]) |=> LP_PERIPH_CLK_EN) // RULE_09
    else $error("low-speed peripheral clock not enabled");
  wait_bound_a: assert property (state_r == SEQ_WAIT_RDY |-> int'(cnt_r) < RDY_TIMEOUT) // RULE_12
    else $error("ready wait overran its limit");
  cal_end_a: assert property ($fell(cal_busy_r) && !$past(wr_cal) |-> // RULE_10
      cal_edges_r == cal_win_r)
    else $error("calibration ended off its window");
endmodule
`default_nettype wire

// ### dv/csc_osc_model.sv
// oscillator bank model standing at the far side of the clock control block
// assumes the bench starts and stops each oscillator through run, one bit per source
`timescale 1ns/1ps
`default_nettype none
module csc_osc_model #(
  parameter int LS_HALF = 8,
  parameter int SLOW_CYC = 12,
  parameter logic [7:0] TRIM_FACT = 8'h5a
) (
  // control clock and reset
  input wire logic clk,
  input wire logic resetn,
  // start requests and start-up speed from the bench
  input wire logic [4:0] run,
  input wire logic slow,
  // running flags, low-speed clock and factory trim lines
  output logic [4:0] osc_rdy,
  output logic ls_clk,
  output logic [7:0] trim_latch
);
  // per-source start-up counters
  int cnt [5];
  // low-speed half period counter
  int ls_cnt;

  // trim lines never move, so capture after reset is safe
  assign trim_latch = TRIM_FACT;

  // five sources start after a prompt or slow delay, stop at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_rdy <= 5'h00;
      for (int i = 0; i < 5; i++) cnt[i] <= 0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (!run[i]) begin
          cnt[i] <= 0;
          osc_rdy[i] <= 1'b0;
        end else if (cnt[i] >= (slow ? SLOW_CYC : 2)) begin
          osc_rdy[i] <= 1'b1;
        end else begin
          cnt[i] <= cnt[i] + 1;
        end
      end
    end
  end

  // low-speed clock runs only while its oscillator runs, else stands low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn || !osc_rdy[1]) begin
      ls_cnt <= 0;
      ls_clk <= 1'b0;
    end else if (ls_cnt == LS_HALF - 1) begin
      ls_cnt <= 0;
      ls_clk <= ~ls_clk;
    end else begin
      ls_cnt <= ls_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### dv/csc_clk_ctrl_tb.sv
// self-checking bench for the clock source control block
// assumes the oscillator model in csc_osc_model and a short ready timeout
`timescale 1ns/1ps
`default_nettype none
module csc_clk_ctrl_tb;
  import csc_pkg::*;
  localparam int TMO = 20; // shortened ready timeout
  localparam int LS_HALF = 8; // low-speed half period in cycles
  localparam logic [7:0] TRIM_FACT = 8'h5a; // arbitrary factory trim
  // bench-driven inputs
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] run = 5'h01;
  logic slow = 1'b0;
  // design outputs and model lines
  logic [31:0] rdata;
  logic [4:0] osc_rdy, src_en;
  logic ls_clk, radio_act, radio_slp, lp_en;
  logic [7:0] trim_in, main_trim;
  logic [2:0] act_src;
  logic [5:0] freq;
  logic [1:0] fwait;
  // reference state and counters
  int n_errors = 0;
  int tests_run = 0;
  int exp_freq = 24;
  int trim_tab [64];
  int vals [10] = '{3, 12, 13, 24, 25, 48, 0, 2, 49, 64};
  int order [5] = '{2, 1, 3, 4, 0};
  logic [31:0] d;

  // 10 MHz control clock
  always #50 clk = ~clk;

  csc_clk_ctrl #(.RDY_TIMEOUT(TMO)) dut_u (
    .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .OSC_RDY(osc_rdy), .LOW_SPEED_CLK_IN(ls_clk), .TRIM_LATCH_IN(trim_in),
    .SRC_EN(src_en), .ACTIVE_SRC(act_src), .MAIN_FREQ_MHZ(freq), .MAIN_TRIM(main_trim),
    .RADIO_ACT_CLK_EN(radio_act), .RADIO_SLP_CLK_EN(radio_slp), .LP_PERIPH_CLK_EN(lp_en),
    .FLASH_WAIT(fwait)
  );

  csc_osc_model #(.LS_HALF(LS_HALF), .TRIM_FACT(TRIM_FACT)) osc_u (
    .clk(clk), .resetn(resetn), .run(run), .slow(slow),
    .osc_rdy(osc_rdy), .ls_clk(ls_clk), .trim_latch(trim_in)
  );

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one-cycle write strobe beside address and data
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // reference flash wait states per source and main frequency
  function automatic int ws_exp(input int s, input int f);
    case (s)
      0: return f > 24 ? 2 : (f > 12 ? 1 : 0);
      2: return 1;
      4: return 2;
      default: return 0;
    endcase
  endfunction

  // switch and check gap length, one-hot result and commit
  task automatic sw(input int s);
    logic [4:0] pre;
    int n;
    int z;
    pre = src_en;
    n = 0;
    z = 0;
    wr_reg(OFS_SRC_SEL, 32'(s));
    #1;
    while (src_en !== 5'h00 && n < 60) begin
      if (src_en !== pre) chk("src_en held", {27'h0, pre}, {27'h0, src_en});
      cyc(1);
      n++;
    end
    chk("ready at gap", 32'h1, {31'h0, osc_rdy[s]});
    while (src_en === 5'h00 && z < 20) begin
      cyc(1);
      z++;
    end
    chk("gap cycles", 32'(GAP_CYC), 32'(z));
    chk("src_en", 32'h1 << s, {27'h0, src_en});
    cyc(1);
    chk("active src", 32'(s), {29'h0, act_src});
    cyc(2);
    chk("flash wait", 32'(ws_exp(s, exp_freq)), {30'h0, fwait});
    rd_reg(OFS_STATUS, d);
    chk("status act", 32'(s), {28'h0, d[3:0]});
  endtask

  // no two gates open at once
  always @(posedge clk) begin
    if (resetn && $countones(src_en) > 1) begin
      n_errors++;
      $display("[ERR] src_en expected one-hot seen %h", src_en);
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[ERR] watchdog expected end seen none");
    finish_test;
  end

  initial begin
    int v;
    int f;
    int t;
    int n;
    d = $urandom(32'h3c04);
    for (int i = 0; i < 64; i++) trim_tab[i] = 0;
    repeat (3) @(posedge clk);
    #1;
    chk("rst src_en", 32'h1, {27'h0, src_en});
    chk("rst freq", 32'h18, {26'h0, freq});
    chk("rst fwait", 32'h2, {30'h0, fwait});
    @(posedge clk);
    resetn <= 1'b1;
    cyc(4);
    chk("fwait 24", 32'h1, {30'h0, fwait});
    chk("trim", {24'h0, TRIM_FACT}, {24'h0, main_trim});
    rd_reg(OFS_TRIM_DATA, d);
    chk("latch trim", {24'h0, TRIM_FACT}, d);
    wr_reg(8'h1c, 32'hffffffff);
    rd_reg(8'h1c, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");

    // frequency sweep with boundaries, clamps and random settings
    for (int i = 0; i < 14; i++) begin
      v = i < 10 ? vals[i] : 3 + int'($urandom % 46);
      f = v > 48 ? 48 : (v < 3 ? 3 : v);
      t = int'($urandom % 256);
      trim_tab[f] = t;
      exp_freq = f;
      wr_reg(OFS_TRIM_IDX, 32'(f));
      wr_reg(OFS_TRIM_DATA, 32'(t));
      wr_reg(OFS_MAIN_FREQ, 32'(v));
      cyc(4);
      chk("freq", 32'(f), {26'h0, freq});
      chk("fwait", 32'(ws_exp(0, f)), {30'h0, fwait});
      chk("main trim", 32'((TRIM_FACT + trim_tab[f]) % 256), {24'h0, main_trim});
      rd_reg(OFS_MAIN_FREQ, d);
      chk("freq read", 32'(f), d);
    end
    $display("test frequency done");

    // radio and peripheral clock enables follow running oscillators
    chk("radio act off", 32'h0, {31'h0, radio_act});
    run <= 5'h1f;
    cyc(8);
    chk("radio act", 32'h1, {31'h0, radio_act});
    chk("radio slp", 32'h1, {31'h0, radio_slp});
    chk("lp clk", 32'h1, {31'h0, lp_en});
    for (int i = 0; i < 5; i++) sw(order[i]);
    $display("test switch done");

    // switch to a stopped source times out and reverts
    run <= 5'h0b;
    cyc(6);
    chk("radio act stop", 32'h0, {31'h0, radio_act});
    chk("lp clk on", 32'h1, {31'h0, lp_en});
    wr_reg(OFS_SRC_SEL, 32'h4);
    cyc(TMO + 10);
    chk("src_en kept", 32'h1, {27'h0, src_en});
    rd_reg(OFS_STATUS, d);
    chk("err set", 32'h1, {31'h0, d[ST_ERR]});
    rd_reg(OFS_SRC_SEL, d);
    chk("sel revert", 32'h0, d);
    wr_reg(OFS_STATUS, 32'h10);
    rd_reg(OFS_STATUS, d);
    chk("err clear", 32'h0, {31'h0, d[ST_ERR]});
    wr_reg(OFS_SRC_SEL, 32'h7);
    rd_reg(OFS_SRC_SEL, d);
    chk("bad code", 32'h0, d);
    slow <= 1'b1;
    run <= 5'h1f;
    sw(4);
    sw(0);
    $display("test refuse done");

    // low-speed calibration window of three periods
    wr_reg(OFS_CAL_CTRL, 32'h3);
    n = 0;
    d = 32'h10000;
    while (d[CAL_BUSY_BIT] !== 1'b0 && n < 60) begin
      rd_reg(OFS_CAL_CTRL, d);
      n++;
    end
    chk("cal busy", 32'h0, {31'h0, d[CAL_BUSY_BIT]});
    rd_reg(OFS_CAL_COUNT, d);
    t = 6 * LS_HALF;
    chk("cal count", 32'h1, 32'(int'(d) >= t - 2 && int'(d) <= t + 2));
    $display("test calibration done");
    finish_test;
  end
endmodule
`default_nettype wire
